// file: logic/prhost_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Encrypted compressed double mode: first word after 12
// - Pause by freezing link clock, either level
// - Abort by dropping request before transfer ends
// - Restart only 20 cycles after a failure
// - Clock keeps toggling through full device reset
// - On fault: retry, full reset, or leave
// - Data moves as 16-bit words
// - Drive request, follow ready, done, fault
// - Compressed mode holds each word four cycles
// - Link clock stays under device maximum
// - Plain stream: first word after four cycles
// - Drop request within eight; clock twenty more
module prhost_ctrl
(
   input  wire logic                          i_mclk,
   input  wire logic                          i_rst_n,
   input  wire logic                          i_start,
   input  wire logic                          i_abort,
   input  wire logic                          i_pause,
   input  wire logic                          i_compressed,
   input  wire logic                          i_enc_double,
   input  wire logic                          i_full_reset,
   input  wire logic [prhost_pkg::WORD_W-1:0] i_word,
   input  wire logic                          i_word_valid,
   input  wire logic                          i_word_last,
   output logic                               o_word_ready,
   input  wire logic                          i_reconfig_rdy,
   input  wire logic                          i_reconfig_complete,
   input  wire logic                          i_reconfig_fault,
   input  wire logic                          i_crc_fault,
   output logic                               o_reconfig_req,
   output logic                               o_reconfig_clk,
   output logic [prhost_pkg::WORD_W-1:0]      o_reconfig_word,
   output logic                               o_busy,
   output logic                               o_done,
   output logic                               o_fault,
   output logic                               o_crc_fault
);

   //------------------------------------------------------------
   // State
   //------------------------------------------------------------
   typedef struct packed {
      logic [2:0]                  sync_a;   // First sync stage
      logic [2:0]                  sync_b;   // Second sync stage
      logic                        crc_a;    // CRC fault first stage
      logic                        crc_b;    // CRC fault second stage
      logic [2:0]                  div;      // Clock divider count
      prhost_pkg::prh_state_t      st;       // Sequencer state
      logic [3:0]                  gap;      // Edges before first word
      logic [2:0]                  hold;     // Edges current word held
      logic [6:0]                  tail;     // Tail and quiet counter
      logic                        cmp;      // Latched compressed flag
      logic                        last;     // Last word on the bus
      prhost_pkg::prh_link_out_t   lnk;      // Pins toward device
      prhost_pkg::prh_stat_t       stat;     // User status
      logic                        wrdy;     // Word accept pulse
   } prh_regs_t;

   // Whole state in one record: one reset line clears it all
   prh_regs_t s_reg;   // Registered state
   prh_regs_t s_next;  // Next state

   // Decoded helpers, all combinational
   logic rdy_s;      // Synchronised ready
   logic cmpl_s;     // Synchronised complete
   logic flt_s;      // Synchronised fault
   logic half_tick;  // Divider wrap
   logic rise;       // Link clock about to rise
   logic fall;       // Link clock about to fall
   logic run_clk;    // Link clock allowed to toggle
   logic ended;      // Device reported done or fault

   // Only the second sync stage feeds logic
   assign rdy_s  = s_reg.sync_b[0];
   assign cmpl_s = s_reg.sync_b[1];
   assign flt_s  = s_reg.sync_b[2];
   assign ended  = cmpl_s | flt_s;

   //------------------------------------------------------------
   // Next state
   //------------------------------------------------------------
   // Data changes on the falling edge so the device samples a
   // settled word on each rising edge of the link clock.
   always_comb
   begin
      s_next        = s_reg;
      s_next.wrdy   = 1'b0;
      // Device status are asynchronous pins: two stages each
      s_next.sync_a = {i_reconfig_fault, i_reconfig_complete,
                       i_reconfig_rdy};
      s_next.sync_b = s_reg.sync_a;
      s_next.crc_a  = i_crc_fault;
      s_next.crc_b  = s_reg.crc_a;
      s_next.stat.crc_fault = s_reg.crc_b;
      // Divider: 320 ns link period, well under the maximum
      half_tick = (s_reg.div == prhost_pkg::DIV_LAST);
      s_next.div = half_tick ? 3'h0 : s_reg.div + 3'h1;
      // Full reset needs a running clock; pause only mid-stream
      run_clk = i_full_reset
              | ((s_reg.st != prhost_pkg::PRH_IDLE)
                 & !(i_pause & (s_reg.st == prhost_pkg::PRH_SEND)));
      rise = half_tick & run_clk & !s_reg.lnk.clk;
      fall = half_tick & run_clk & s_reg.lnk.clk;
      // Toggle on each enabled half period
      if (rise | fall)
      begin
         s_next.lnk.clk = !s_reg.lnk.clk;
      end
      // Busy lags the state by one cycle, which is harmless
      s_next.stat.busy = (s_reg.st != prhost_pkg::PRH_IDLE);
      // Sequencer: request, ready, gap, stream, tail, quiet
      unique case (s_reg.st)
         prhost_pkg::PRH_IDLE:
         begin
            // A start during a full device reset is refused
            if (i_start & !i_full_reset)
            begin
               s_next.lnk.req   = 1'b1;
               s_next.cmp       = i_compressed;
               s_next.stat.done  = 1'b0;
               s_next.stat.fault = 1'b0;
               s_next.st        = prhost_pkg::PRH_WAIT_RDY;
            end
         end
         prhost_pkg::PRH_WAIT_RDY:
         begin
            // Wait for the device to raise ready
            if (i_abort | ended)
            begin
               s_next.lnk.req = 1'b0;
               s_next.tail    = 7'h0;
               s_next.st      = prhost_pkg::PRH_TAIL;
            end
            else if (rdy_s)
            begin
               if (i_enc_double & s_reg.cmp)
                  s_next.gap = prhost_pkg::GAP_ENC_CMP;
               else if (i_enc_double)
                  s_next.gap = prhost_pkg::GAP_ENC_DBL;
               else
                  s_next.gap = prhost_pkg::GAP_PLAIN;
               s_next.st = prhost_pkg::PRH_GAP;
            end
         end
         prhost_pkg::PRH_GAP:
         begin
            // Count exact rising edges before the first word
            if (i_abort)
            begin
               s_next.lnk.req = 1'b0;
               s_next.tail    = 7'h0;
               s_next.st      = prhost_pkg::PRH_TAIL;
            end
            else if (fall & (s_reg.gap == 4'h1))
            begin
               s_next.lnk.word = i_word;
               s_next.last     = i_word_last;
               s_next.wrdy     = 1'b1;
               s_next.hold     = 3'h0;
               s_next.st       = prhost_pkg::PRH_SEND;
            end
            else if (rise)
            begin
               s_next.gap = s_reg.gap - 4'h1;
            end
         end
         prhost_pkg::PRH_SEND:
         begin
            // Stream words; a missing word leaves the old one on the bus while the clock runs on
            if (i_abort | ended)
            begin
               s_next.lnk.req = 1'b0;
               s_next.tail    = 7'h0;
               s_next.st      = prhost_pkg::PRH_TAIL;
            end
            else if (rise)
            begin
               s_next.hold = s_reg.hold + 3'h1;
            end
            else if (fall & !s_reg.last & i_word_valid
                     & (!s_reg.cmp
                        | (s_reg.hold == prhost_pkg::CMP_HOLD)))
            begin
               s_next.lnk.word = i_word;
               s_next.last     = i_word_last;
               s_next.wrdy     = 1'b1;
               s_next.hold     = 3'h0;
            end
         end
         prhost_pkg::PRH_TAIL:
         begin
            // Request is already low, far inside the eight-edge limit
            s_next.lnk.req = 1'b0;
            if (cmpl_s)
               s_next.stat.done = 1'b1;
            if (flt_s)
               s_next.stat.fault = 1'b1;
            if (rise)
               s_next.tail = s_reg.tail + 7'h1;
            // Tail counts rising edges; compressed needs the longer one
            if (s_reg.tail == (s_reg.cmp ? prhost_pkg::TAIL_CMP
                                         : prhost_pkg::TAIL_PLAIN))
            begin
               s_next.tail = 7'h0;
               s_next.st   = prhost_pkg::PRH_QUIET;
            end
         end
         prhost_pkg::PRH_QUIET:
         begin
            // Keep clocking until the restart spacing has passed
            if (flt_s)
               s_next.stat.fault = 1'b1;
            if (rise & !ended)
               s_next.tail = s_reg.tail + 7'h1;
            // Counting only starts once the device lets its flags go
            if (s_reg.tail == prhost_pkg::RESTART_GAP)
               s_next.st = prhost_pkg::PRH_IDLE;
         end
      endcase
      // Synchronous reset wins over everything above
      if (!i_rst_n)
      begin
         s_next = '0;
         s_next.st = prhost_pkg::PRH_IDLE;
      end
   end

   //------------------------------------------------------------
   // Register
   //------------------------------------------------------------
   // Single register stage for the whole record
   always_ff @(posedge i_mclk)
   begin
      s_reg <= s_next;
   end

   //------------------------------------------------------------
   // Outputs
   //------------------------------------------------------------
   // Pins come straight from flops: no glitches toward the device
   assign o_reconfig_req  = s_reg.lnk.req;
   assign o_reconfig_clk  = s_reg.lnk.clk;
   assign o_reconfig_word = s_reg.lnk.word;
   assign o_word_ready    = s_reg.wrdy;
   assign o_busy          = s_reg.stat.busy;
   assign o_done          = s_reg.stat.done;
   assign o_fault         = s_reg.stat.fault;
   assign o_crc_fault     = s_reg.stat.crc_fault;

   //------------------------------------------------------------
   // Checks
   //------------------------------------------------------------
   // Device finished or failed while words were streaming
   sequence seq_end_seen;
      (s_reg.st == prhost_pkg::PRH_SEND) && ended;
   endsequence

   // Request must fall on the very next cycle
   chk_req_drop: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      seq_end_seen |=> !o_reconfig_req)
      else $error("request not dropped after end");
   // Every compressed word after the first sits four rising edges
   chk_cmp_hold: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      (o_word_ready && s_reg.cmp
       && $past(s_reg.st) == prhost_pkg::PRH_SEND)
      |-> $past(s_reg.hold) == prhost_pkg::CMP_HOLD)
      else $error("compressed word held wrong length");
   // Frozen link clock while paused mid-stream
   chk_pause_clk: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      (i_pause && !i_full_reset && s_reg.st == prhost_pkg::PRH_SEND)
      |=> $stable(o_reconfig_clk))
      else $error("link clock moved while paused");
   // Four cycles of full reset always hold exactly one link edge; the
   // window looks back, so cycles after a full reset ends are not judged
   chk_rst_clk: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      i_full_reset [*4] |=> o_reconfig_clk != $past(o_reconfig_clk, 4))
      else $error("link clock idle in full reset");
   // Abort in any active phase drops the request at once
   chk_abort_req: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      (i_abort && s_reg.st inside {prhost_pkg::PRH_WAIT_RDY,
         prhost_pkg::PRH_GAP, prhost_pkg::PRH_SEND}) |=> !o_reconfig_req)
      else $error("abort did not drop request");
   // No request while the restart spacing runs
   chk_no_restart: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      (s_reg.st == prhost_pkg::PRH_QUIET) |=> !o_reconfig_req)
      else $error("request raised during restart gap");
endmodule // prhost_ctrl
`default_nettype wire

// file: logic/prhost_pkg.sv
package prhost_pkg;
   // Bitstream word width
   localparam int WORD_W = 16;
   // Divider: reconfig_clk half period in system clocks (40 ns * 4 = 160 ns)
   localparam int DIV_HALF = 4;
   localparam logic [2:0] DIV_LAST = 3'h3;
   // Gap from ready to first word, in link clock cycles
   localparam logic [3:0] GAP_PLAIN = 4'h4;
   localparam logic [3:0] GAP_ENC_DBL = 4'h8;
   localparam logic [3:0] GAP_ENC_CMP = 4'hc;
   // Link clocks each compressed word is held
   localparam logic [2:0] CMP_HOLD = 3'h4;
   // Request must drop within this many link clocks of done/fault
   localparam logic [3:0] REQ_DROP_MAX = 4'h8;
   // Link clocks kept running after done/fault
   localparam logic [6:0] TAIL_PLAIN = 7'h14;
   localparam logic [6:0] TAIL_CMP = 7'h50;
   // Quiet link clocks before a restart may be requested
   localparam logic [6:0] RESTART_GAP = 7'h14;
   // Sequencer states
   typedef enum logic [2:0] {
      PRH_IDLE, PRH_WAIT_RDY, PRH_GAP, PRH_SEND, PRH_TAIL, PRH_QUIET
   } prh_state_t;
   // Signals driven toward the device
   typedef struct packed {
      logic              req;
      logic              clk;
      logic [WORD_W-1:0] word;
   } prh_link_out_t;
   // Status toward the user
   typedef struct packed {
      logic busy;
      logic done;
      logic fault;
      logic crc_fault;
   } prh_stat_t;
endpackage

// file: verif/prhost_dev_model.sv
`timescale 1ns/1ns
`default_nettype none
// Behavioural device end of the reconfiguration link
module prhost_dev_model
(
   input  wire logic                          i_req,
   input  wire logic                          i_clk,
   input  wire logic [prhost_pkg::WORD_W-1:0] i_word,
   input  wire logic [3:0]                    i_gap,
   input  wire logic                          i_cmp,
   input  wire logic [7:0]                    i_nwords,
   input  wire logic                          i_crc_inj,
   output logic                               o_rdy = 1'b0,
   output logic                               o_complete = 1'b0,
   output logic                               o_fault = 1'b0,
   output logic                               o_crc
);
   int wait_n = 0; // Edges since request seen
   int edge_n = 0; // Edges since ready
   int got    = 0; // Words taken
   int low_n  = 0; // Edges with request low
   // Status lines are plain levels, nothing else rides on them
   assign o_crc = i_crc_inj;
   // A stopped link clock freezes everything, data bus included
   always @(posedge i_clk)
   begin
      if (!i_req)
      begin
         if (o_rdy) o_fault <= 1'b1;
         o_rdy  <= 1'b0;
         wait_n <= 0;
         low_n  <= low_n + 1;
         if (low_n > 10) {o_complete, o_fault} <= 2'b00;
      end
      else if (!o_rdy && !o_complete && !o_fault)
      begin
         low_n  <= 0;
         wait_n <= wait_n + 1;
         edge_n <= 0;
         got    <= 0;
         if (wait_n == 3) o_rdy <= 1'b1;
      end
      else if (o_rdy)
      begin
         edge_n <= edge_n + 1;
         // Word slot: the gap-th rising edge after ready, then every
         // edge or every fourth
         if (edge_n + 1 >= i_gap
             && (edge_n + 1 - i_gap) % (i_cmp ? 4 : 1) == 0)
         begin
            got <= got + 1;
            if (i_word !== 16'ha000 + got[15:0])
               {o_rdy, o_fault} <= 2'b01;
            else if (got + 1 == i_nwords)
               {o_rdy, o_complete} <= 2'b01;
         end
      end
   end
endmodule // prhost_dev_model
`default_nettype wire

// file: verif/tb_partial_reconfig_port.sv
`timescale 1ns/1ns
`default_nettype none
module tb_partial_reconfig_port;
   logic mclk = 1'b0, rst_n = 1'b0, start = 1'b0, abort = 1'b0;
   logic pause = 1'b0, cmp = 1'b0, encd = 1'b0, full_rst = 1'b0;
   logic crc_inj = 1'b0, last = 1'b0, pl;
   logic [15:0] word = 16'h0000, base = 16'ha000, lword;
   logic [3:0]  gap = 4'h4;
   logic [7:0]  nwords = 8'h06;
   logic rdy, cmpl, flt, crc, wrdy, req, lclk, busy, done, fault, crcf;
   int idx = 0, mismatches = 0, total_checks = 0, n;
   time t0; // Moment the abort fault showed
   initial forever #20 mclk = ~mclk;
   prhost_ctrl u_dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_start(start),
      .i_abort(abort), .i_pause(pause), .i_compressed(cmp),
      .i_enc_double(encd), .i_full_reset(full_rst), .i_word(word),
      .i_word_valid(1'b1), .i_word_last(last), .o_word_ready(wrdy),
      .i_reconfig_rdy(rdy), .i_reconfig_complete(cmpl),
      .i_reconfig_fault(flt), .i_crc_fault(crc), .o_reconfig_req(req),
      .o_reconfig_clk(lclk), .o_reconfig_word(lword), .o_busy(busy),
      .o_done(done), .o_fault(fault), .o_crc_fault(crcf));
   prhost_dev_model u_dev (.i_req(req), .i_clk(lclk), .i_word(lword),
      .i_gap(gap), .i_cmp(cmp), .i_nwords(nwords), .i_crc_inj(crc_inj),
      .o_rdy(rdy), .o_complete(cmpl), .o_fault(flt), .o_crc(crc));
   // Feeder: next word after each acceptance; an idle host rewinds
   // to word 0, so the index never hangs on the start strobe's timing
   always @(negedge mclk)
   begin
      if (busy !== 1'b1) idx = 0;
      else if (wrdy === 1'b1) idx = idx + 1;
      word <= base + idx[15:0];
      last <= (idx + 1 == nwords);
   end
   //------------------------------------------------------------
   // Checking and verdict
   //------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Count link clock rises over a span of system clocks
   task automatic rises(input int cyc);
      n = 0;
      pl = lclk;
      repeat (cyc)
      begin
         @(negedge mclk);
         if (lclk && !pl) n++;
         pl = lclk;
      end
   endtask
   // Start held until request shows; covers the quiet spell
   task automatic start_req(input logic c, input logic e, input logic [3:0] g);
      cmp = c;
      encd = e;
      gap = g;
      start = 1'b1;
      for (int i = 0; i < 2000 && req !== 1'b1; i++) @(negedge mclk);
      start = 1'b0;
   endtask
   task automatic finish_xfer(input logic ok);
      for (int i = 0; i < 6000 && (done | fault) !== 1'b1; i++)
         @(negedge mclk);
      check(done, ok);
      check(fault, !ok);
      // Request is already low when the flag shows
      check(req, 1'b0);
      // At least twenty link edges follow the end
      rises(168);
      check(n >= 20, 1'b1);
      for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(negedge mclk);
   endtask
   //------------------------------------------------------------
   // Scenarios
   //------------------------------------------------------------
   task automatic t_modes();
      start_req(1'b0, 1'b0, prhost_pkg::GAP_PLAIN);
      finish_xfer(1'b1);
      start_req(1'b1, 1'b0, prhost_pkg::GAP_PLAIN);
      finish_xfer(1'b1);
      start_req(1'b0, 1'b1, prhost_pkg::GAP_ENC_DBL);
      finish_xfer(1'b1);
      start_req(1'b1, 1'b1, prhost_pkg::GAP_ENC_CMP);
      finish_xfer(1'b1);
      $display("test modes done");
   endtask
   task automatic t_pause();
      nwords = 8'h0c;
      start_req(1'b0, 1'b0, prhost_pkg::GAP_PLAIN);
      for (int i = 0; i < 2000 && idx < 3; i++) @(negedge mclk);
      pause = 1'b1;
      repeat (10) @(negedge mclk);
      rises(80);
      check(n, 0);
      pause = 1'b0;
      finish_xfer(1'b1);
      nwords = 8'h06;
      $display("test pause done");
   endtask
   task automatic t_abort();
      start_req(1'b0, 1'b0, prhost_pkg::GAP_PLAIN);
      for (int i = 0; i < 2000 && idx < 2; i++) @(negedge mclk);
      abort = 1'b1;
      for (int i = 0; i < 200 && fault !== 1'b1; i++) @(negedge mclk);
      abort = 1'b0;
      check(fault, 1'b1);
      check(req, 1'b0);
      t0 = $time;
      start_req(1'b0, 1'b0, prhost_pkg::GAP_PLAIN);
      check($time - t0 >= 20 * 320, 1'b1);
      finish_xfer(1'b1);
      $display("test abort done");
   endtask
   task automatic t_misc();
      base = 16'hb000;
      start_req(1'b0, 1'b0, prhost_pkg::GAP_PLAIN);
      finish_xfer(1'b0);
      base = 16'ha000;
      crc_inj = 1'b1;
      repeat (6) @(negedge mclk);
      check(crcf, 1'b1);
      crc_inj = 1'b0;
      full_rst = 1'b1;
      start = 1'b1;
      rises(200);
      check(n >= 20, 1'b1);
      check(req, 1'b0);
      {full_rst, start} = 2'b00;
      $display("test misc done");
   endtask
   initial
   begin
      repeat (5) @(negedge mclk);
      rst_n = 1'b1;
      t_modes();
      t_pause();
      t_abort();
      t_misc();
      tally_and_finish();
   end
   // Watchdog well beyond the expected run
   initial
   begin
      #3000000;
      mismatches++;
      tally_and_finish();
   end
endmodule // tb_partial_reconfig_port
`default_nettype wire
